/* core/rpcs_pkg.sv */
// Constants for the register page context stack.
// Assumes an 8-bit special function register bus with byte addresses 0x80-0xFF.
package rpcs_pkg;
    localparam logic [7:0] ADDR_PAGE_SELECTOR = 8'h84;
    localparam logic [7:0] ADDR_STACK_SECOND = 8'h85;
    localparam logic [7:0] ADDR_STACK_BOTTOM = 8'h86;
    localparam logic [7:0] ADDR_AUTO_PAGE_CONTROL = 8'h96;
    localparam logic [7:0] PAGE_CONTROL = 8'h0F;
    localparam int AUTO_PAGE_ENABLE_BIT = 0;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic RST_AUTO_PAGE_ENABLE = 1'b1;
    localparam int STACK_DEPTH = 3;
    typedef enum logic [1:0] {
        RPCS_HOLD,
        RPCS_PUSH,
        RPCS_POP
    } rpcs_shift_t;
endpackage : rpcs_pkg

/* core/rpcs_page_stack.sv */
// Page selector, three-entry page context stack and auto paging control.
// Assumes the core gives one-cycle entry and return strobes and a
// synchronous register port that reads combinationally.
`timescale 1ns/1ps
module rpcs_page_stack
    import rpcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Core interrupt sequencing
    input wire logic irq_entry,
    input wire logic [7:0] irq_page,
    input wire logic irq_return,
    // Page in use
    output logic [7:0] page_selector,
    output logic auto_page_enable
);
    import rpcs_pkg::*;

    logic [7:0] stack_ff [STACK_DEPTH];
    logic [7:0] nxt_stack [STACK_DEPTH];
    logic enable_ff;
    logic nxt_enable;
    logic [STACK_DEPTH-1:0] wr_entry;
    logic wr_ctrl;
    logic hit_ctrl;
    rpcs_shift_t shift;

    assign hit_ctrl = (reg_addr == ADDR_AUTO_PAGE_CONTROL) && (stack_ff[0] == PAGE_CONTROL);

    // Address decode of the stack bytes, all pages
    always_comb begin
        wr_entry[0] = reg_wr && (reg_addr == ADDR_PAGE_SELECTOR);
        wr_entry[1] = reg_wr && (reg_addr == ADDR_STACK_SECOND);
        wr_entry[2] = reg_wr && (reg_addr == ADDR_STACK_BOTTOM);
        wr_ctrl = reg_wr && hit_ctrl;
    end

    // Shift only from core strobes; entry has priority if both seen
    always_comb begin
        shift = RPCS_HOLD;
        if (enable_ff && irq_entry) begin
            shift = RPCS_PUSH;
        end else if (enable_ff && irq_return) begin
            shift = RPCS_POP;
        end
    end

    always_comb begin
        for (int i = 0; i < STACK_DEPTH; i++) begin
            nxt_stack[i] = stack_ff[i];
        end
        case (shift)
            RPCS_PUSH: begin
                nxt_stack[0] = irq_page;
                nxt_stack[1] = stack_ff[0];
                nxt_stack[2] = stack_ff[1];
            end
            RPCS_POP: begin
                nxt_stack[0] = stack_ff[1];
                nxt_stack[1] = stack_ff[2];
                nxt_stack[2] = RST_PAGE;
            end
            RPCS_HOLD: begin
                // Direct writes change one byte, never shift
                for (int i = 0; i < STACK_DEPTH; i++) begin
                    if (wr_entry[i]) begin
                        nxt_stack[i] = reg_wdata;
                    end
                end
            end
            default: begin
                nxt_stack[0] = stack_ff[0];
            end
        endcase
        // Software write loses against a shift in the same cycle
    end

    // Control byte is applied even in a shift cycle; reserved bits dropped
    always_comb begin
        nxt_enable = enable_ff;
        if (wr_ctrl) begin
            nxt_enable = reg_wdata[AUTO_PAGE_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_ff[i] <= RST_PAGE;
            end
        end else begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_ff[i] <= nxt_stack[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_ff <= RST_AUTO_PAGE_ENABLE;
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    // Read mux; reserved control bits read zero
    always_comb begin
        reg_rdata = 8'h00;
        reg_hit = 1'b1;
        if (reg_addr == ADDR_PAGE_SELECTOR) begin
            reg_rdata = stack_ff[0];
        end else if (reg_addr == ADDR_STACK_SECOND) begin
            reg_rdata = stack_ff[1];
        end else if (reg_addr == ADDR_STACK_BOTTOM) begin
            reg_rdata = stack_ff[2];
        end else if (hit_ctrl) begin
            reg_rdata = {7'h00, enable_ff};
        end else begin
            reg_hit = 1'b0;
        end
    end

    assign page_selector = stack_ff[0];
    assign auto_page_enable = enable_ff;

    chk_entry_loads_page: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && enable_ff) |=> (page_selector == $past(irq_page)))
        else $error("entry did not load source page");
    chk_entry_disabled_hold: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && !enable_ff && !wr_entry[0]) |=> $stable(page_selector))
        else $error("page changed on disabled entry");
    chk_push_shifts_down: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && enable_ff) |=> (stack_ff[1] == $past(stack_ff[0]) && stack_ff[2] == $past(stack_ff[1])))
        else $error("push did not shift stack");
    chk_pop_shifts_up: assert property (@(posedge clk) disable iff (srst)
        (irq_return && !irq_entry && enable_ff) |=> (stack_ff[0] == $past(stack_ff[1])
        && stack_ff[1] == $past(stack_ff[2]) && stack_ff[2] == 8'h00))
        else $error("pop did not shift stack");
    chk_second_write: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[1] && shift == RPCS_HOLD) |=> (stack_ff[1] == $past(reg_wdata) && $stable(stack_ff[0])))
        else $error("second write wrong");
    chk_bottom_write: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[2] && shift == RPCS_HOLD) |=> (stack_ff[2] == $past(reg_wdata) && $stable(stack_ff[1])))
        else $error("bottom write wrong");
    chk_no_soft_shift: assert property (@(posedge clk) disable iff (srst)
        (!irq_entry && !irq_return && !wr_entry[1] && !wr_entry[2]) |=> $stable(stack_ff[1]) && $stable(stack_ff[2]))
        else $error("stack moved without interrupt");
    chk_shift_wins: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[0] && irq_entry && enable_ff) |=> (page_selector == $past(irq_page)))
        else $error("write beat push");
    chk_ctrl_page_only: assert property (@(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == ADDR_AUTO_PAGE_CONTROL && page_selector != PAGE_CONTROL) |=> $stable(enable_ff))
        else $error("control written off page F");
    chk_disabled_no_pop: assert property (@(posedge clk) disable iff (srst)
        (irq_return && !enable_ff && !reg_wr) |=> $stable(page_selector) && $stable(stack_ff[1]))
        else $error("pop while disabled");

    // Register port checks
    chk_selector_write: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[0] && shift == RPCS_HOLD)
        |=> (page_selector == $past(reg_wdata)))
        else $error("selector write lost");

    chk_selector_no_shift: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[0] && !irq_entry && !irq_return)
        |=> ($stable(stack_ff[1]) && $stable(stack_ff[2])))
        else $error("selector write moved stack");

    chk_read_selector: assert property (@(posedge clk) disable iff (srst)
        (reg_addr == ADDR_PAGE_SELECTOR)
        |-> (reg_hit && reg_rdata == page_selector))
        else $error("selector read wrong");

    chk_read_second: assert property (@(posedge clk) disable iff (srst)
        (reg_addr == ADDR_STACK_SECOND)
        |-> (reg_hit && reg_rdata == stack_ff[1]))
        else $error("second read wrong");

    chk_read_bottom: assert property (@(posedge clk) disable iff (srst)
        (reg_addr == ADDR_STACK_BOTTOM)
        |-> (reg_hit && reg_rdata == stack_ff[2]))
        else $error("bottom read wrong");

    chk_read_ctrl: assert property (@(posedge clk) disable iff (srst)
        (reg_addr == ADDR_AUTO_PAGE_CONTROL && page_selector == PAGE_CONTROL)
        |-> (reg_hit && reg_rdata == {7'h00, auto_page_enable}))
        else $error("control read wrong");

    chk_ctrl_hidden: assert property (@(posedge clk) disable iff (srst)
        (reg_addr == ADDR_AUTO_PAGE_CONTROL && page_selector != PAGE_CONTROL)
        |-> (!reg_hit && reg_rdata == 8'h00))
        else $error("control visible off page F");

    chk_ctrl_write: assert property (@(posedge clk) disable iff (srst)
        (reg_wr && reg_addr == ADDR_AUTO_PAGE_CONTROL && page_selector == PAGE_CONTROL)
        |=> (auto_page_enable == $past(reg_wdata[AUTO_PAGE_ENABLE_BIT])))
        else $error("control write lost");

    chk_ctrl_stable: assert property (@(posedge clk) disable iff (srst)
        !(reg_wr && reg_addr == ADDR_AUTO_PAGE_CONTROL && page_selector == PAGE_CONTROL)
        |=> $stable(auto_page_enable))
        else $error("enable changed without write");

    chk_unmapped_quiet: assert property (@(posedge clk) disable iff (srst)
        (reg_addr != ADDR_PAGE_SELECTOR && reg_addr != ADDR_STACK_SECOND && reg_addr != ADDR_STACK_BOTTOM
        && reg_addr != ADDR_AUTO_PAGE_CONTROL) |-> (!reg_hit && reg_rdata == 8'h00))
        else $error("unmapped address answered");

    // Direct stack writes
    chk_second_keeps_bottom: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[1] && shift == RPCS_HOLD)
        |=> $stable(stack_ff[2]))
        else $error("second write moved bottom");

    chk_bottom_keeps_top: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[2] && shift == RPCS_HOLD)
        |=> $stable(stack_ff[0]))
        else $error("bottom write moved top");

    chk_second_feeds_return: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[1] && shift == RPCS_HOLD) ##1 (irq_return && !irq_entry && enable_ff)
        |=> (page_selector == $past(reg_wdata, 2)))
        else $error("written second not restored");

    chk_bottom_feeds_second: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[2] && shift == RPCS_HOLD) ##1 (irq_return && !irq_entry && enable_ff)
        |=> (stack_ff[1] == $past(reg_wdata, 2)))
        else $error("written bottom not moved up");

    // Interrupt sequencing and reset values
    chk_return_restores: assert property (@(posedge clk) disable iff (srst)
        (irq_return && !irq_entry && enable_ff)
        |=> (page_selector == $past(stack_ff[1])))
        else $error("return did not restore page");

    chk_entry_return_pair: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && enable_ff) ##1 (irq_return && !irq_entry && enable_ff)
        |=> (page_selector == $past(stack_ff[0], 2) && stack_ff[1] == $past(stack_ff[1], 2)))
        else $error("entry and return not paired");

    chk_disabled_entry_stack: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && !enable_ff && !reg_wr)
        |=> ($stable(stack_ff[1]) && $stable(stack_ff[2])))
        else $error("push while disabled");

    chk_disabled_return_bottom: assert property (@(posedge clk) disable iff (srst)
        (irq_return && !enable_ff && !reg_wr)
        |=> $stable(stack_ff[2]))
        else $error("bottom moved while disabled");

    chk_push_drops_write: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[1] && irq_entry && enable_ff)
        |=> (stack_ff[1] == $past(stack_ff[0])))
        else $error("second write beat push");

    chk_pop_drops_write: assert property (@(posedge clk) disable iff (srst)
        (wr_entry[2] && irq_return && !irq_entry && enable_ff)
        |=> (stack_ff[2] == RST_PAGE))
        else $error("bottom write beat pop");

    chk_entry_beats_return: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && irq_return && enable_ff)
        |=> (page_selector == $past(irq_page) && stack_ff[1] == $past(stack_ff[0])))
        else $error("return beat entry");

    chk_two_pushes: assert property (@(posedge clk) disable iff (srst)
        (irq_entry && enable_ff) ##1 (irq_entry && enable_ff)
        |=> (stack_ff[2] == $past(stack_ff[0], 2)))
        else $error("bottom not overwritten");

    chk_reset_values: assert property (@(posedge clk)
        srst |=> (page_selector == RST_PAGE && stack_ff[1] == RST_PAGE && stack_ff[2] == RST_PAGE
        && auto_page_enable == RST_AUTO_PAGE_ENABLE))
        else $error("reset values wrong");

    // Each entry holds unless its own write or a shift moves it
    for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_entry_hold
        chk_entry_holds: assert property (@(posedge clk) disable iff (srst)
            (!wr_entry[g] && shift == RPCS_HOLD) |=> $stable(stack_ff[g]))
            else $error("stack entry changed with no cause");
    end

endmodule : rpcs_page_stack

/* dv/rpcs_core_model.sv */
// Core interrupt sequencing model: one-cycle entry and return strobes.
// Assumes the bench asks for each strobe one cycle ahead.
`timescale 1ns/1ps
module rpcs_core_model (
    // Clock and requests
    input wire logic clk,
    input wire logic want_entry,
    input wire logic want_return,
    input wire logic [7:0] want_page,
    // Strobes to the stack
    output logic irq_entry,
    output logic irq_return,
    output logic [7:0] irq_page
);
    // Page valid only with entry; inverted otherwise so stale use shows
    always_ff @(posedge clk) begin
        irq_entry <= want_entry;
        irq_return <= want_return;
        irq_page <= want_entry ? want_page : ~irq_page;
    end
endmodule : rpcs_core_model

/* dv/register_page_context_stack_test.sv */
// Self-checking bench for the page context stack.
// Assumes a core model in front of the strobes; 50 MHz clock.
`timescale 1ns/1ps
module register_page_context_stack_test;
    import rpcs_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic we = 1'b0;
    logic wr_ = 1'b0;
    logic [7:0] wp = 8'h00;
    logic [7:0] reg_rdata, page_selector, irq_page, t, s, b;
    logic reg_hit, auto_page_enable, irq_entry, irq_return, en;
    logic [7:0] tbl [5] = '{ADDR_PAGE_SELECTOR, ADDR_STACK_SECOND, ADDR_STACK_BOTTOM, ADDR_AUTO_PAGE_CONTROL, 8'hC3};
    int miscompares = 0;
    int num_checks = 0;
    int seed;
    rpcs_page_stack DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .irq_entry(irq_entry), .irq_page(irq_page),
        .irq_return(irq_return), .page_selector(page_selector), .auto_page_enable(auto_page_enable));
    rpcs_core_model core (.clk(clk), .want_entry(we), .want_return(wr_), .want_page(wp),
        .irq_entry(irq_entry), .irq_return(irq_return), .irq_page(irq_page));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [8:0] exp_rd(input logic [7:0] a);
        if (a == ADDR_PAGE_SELECTOR) return {1'b1, t};
        if (a == ADDR_STACK_SECOND) return {1'b1, s};
        if (a == ADDR_STACK_BOTTOM) return {1'b1, b};
        if (a == ADDR_AUTO_PAGE_CONTROL && t == PAGE_CONTROL) return {1'b1, 7'h00, en};
        return 9'h000;
    endfunction : exp_rd
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : check
    task automatic rd_all;
        foreach (tbl[i]) begin
            @(posedge clk);
            reg_addr <= tbl[i];
            #1;
            check({reg_hit, reg_rdata}, exp_rd(tbl[i]));
            check({auto_page_enable, page_selector}, {en, t});
        end
    endtask : rd_all
    task automatic op(input logic e, input logic r, input logic [7:0] p, input logic w, input logic [7:0] a,
        input logic [7:0] d);
        logic sh;
        sh = en && (e || r);
        @(posedge clk);
        we <= e;
        wr_ <= r;
        wp <= p;
        @(posedge clk);
        we <= 1'b0;
        wr_ <= 1'b0;
        reg_addr <= a;
        reg_wr <= w;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (w && a == ADDR_AUTO_PAGE_CONTROL && t == PAGE_CONTROL) en = d[0];
        if (sh && e) {t, s, b} = {p, t, s};
        else if (sh) {t, s, b} = {s, b, 8'h00};
        else if (w && a == ADDR_PAGE_SELECTOR) t = d;
        else if (w && a == ADDR_STACK_SECOND) s = d;
        else if (w && a == ADDR_STACK_BOTTOM) b = d;
        rd_all();
    endtask : op
    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        // Long margin; the run takes about 50 us
        #400us;
        miscompares++;
        wrap_up();
    end
    initial begin
        seed = $urandom(83);
        {t, s, b, en} = {RST_PAGE, RST_PAGE, RST_PAGE, RST_AUTO_PAGE_ENABLE};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd_all();
        op(1'b0, 1'b0, 8'h00, 1'b1, ADDR_PAGE_SELECTOR, PAGE_CONTROL);
        op(1'b1, 1'b0, 8'h21, 1'b0, 8'h00, 8'h00);
        op(1'b1, 1'b0, 8'h42, 1'b1, ADDR_STACK_SECOND, 8'hAA);
        op(1'b0, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b0, 8'h00, 1'b1, ADDR_AUTO_PAGE_CONTROL, 8'hFE);
        op(1'b1, 1'b0, 8'h33, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b1, 8'h00, 1'b1, ADDR_AUTO_PAGE_CONTROL, 8'h01);
        repeat (300) begin
            op(1'($urandom), 1'($urandom), 8'($urandom), 1'($urandom), tbl[$urandom % 5],
                ($urandom % 3 == 0) ? PAGE_CONTROL : 8'($urandom));
        end
        // Mid-run reset must clear the stack and re-enable auto paging
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        {t, s, b, en} = {RST_PAGE, RST_PAGE, RST_PAGE, RST_AUTO_PAGE_ENABLE};
        rd_all();
        op(1'b1, 1'b0, 8'h5A, 1'b0, 8'h00, 8'h00);
        wrap_up();
    end
endmodule : register_page_context_stack_test
